/* common/mctc_pkg.sv */
/*
  Shared constants and types of the motor control timer core.
  Assumes one clock domain and plain configuration ports.
*/
`default_nettype none
package mctc_pkg;
  localparam int CH_N = 8;                          // Channels
  localparam int PAIR_N = 4;                        // Channel pairs
  localparam int FLT_N = 4;                         // Fault inputs
  localparam int FILT_CH = 4;                       // Channels that carry an input filter
  localparam int CNT_W = 16;                        // Counter width
  localparam int SYNC_W = 16;                       // Width of the pin synchroniser bank
  localparam int PS_W = 7;                          // Prescaler counter width, ratio up to 128
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;  // Counter and value reset
  localparam logic [CNT_W-1:0] FREE_MAX = 16'hFFFF; // Free-running upper limit
  localparam logic [CNT_W-1:0] FREE_MIN = 16'h0000; // Free-running lower limit
  localparam logic [2:0] FILT_LEN = 3'h4;           // Cycles an input must hold to pass the filter
  localparam logic [5:0] DT_RST = 6'h00;            // Deadtime counter reset
  // Positions inside the synchroniser bank
  localparam int SY_EXT = 0;
  localparam int SY_FIX = 1;
  localparam int SY_PHA = 2;
  localparam int SY_PHB = 3;
  localparam int SY_FLT = 4;
  localparam int SY_CH = 8;

  // Counter source
  typedef enum logic [1:0] {
    CS_NONE  = 2'b00,
    CS_SYS   = 2'b01,
    CS_FIXED = 2'b10,
    CS_EXT   = 2'b11
  } mctc_clksel_e;

  // Channel operating mode; it alone sets the pin direction
  typedef enum logic [1:0] {
    CM_CAPTURE = 2'b00,
    CM_COMPARE = 2'b01,
    CM_PWM     = 2'b10,
    CM_OFF     = 2'b11
  } mctc_chmode_e;

  // Capture edge or compare action, shared field
  typedef enum logic [1:0] {
    ACT_TOGGLE = 2'b00,  // Compare toggle; capture both edges
    ACT_RISE   = 2'b01,  // Compare set; capture rising
    ACT_FALL   = 2'b10,  // Compare clear; capture falling
    ACT_BOTH   = 2'b11   // Compare toggle; capture both edges
  } mctc_act_e;

  // Per-channel setup
  typedef struct packed {
    mctc_chmode_e mode;
    mctc_act_e    act;
    logic         filt_en;
  } mctc_chcfg_s;

  // Per-pair setup
  typedef struct packed {
    logic       combine;           // One waveform, edges from both channels
    logic       comp;              // Odd channel is the inverse of the even one
    logic [5:0] deadtime;          // Cycles both outputs stay inactive on a switch
    logic       dual_cap;          // Even captures rise, odd captures fall of even input
    logic       pair_fault_enable;
    logic [1:0] pair_fault_mode;   // Zero disables fault action for the pair
  } mctc_pair_s;
endpackage
`default_nettype wire

/* hdl/mctc_top.sv */
/*
  Motor control timer core: counter, prescaler, eight channels, pair logic,
  deadtime, polarity, faults and quadrature decoding.
  Assumes plain configuration ports on ref_clk; channel, fault,
  encoder and clock pins are asynchronous, synchronised here.
*/
// Behaviour
// - 16-bit counter, unsigned or signed
// - Prescaler ratios one through 128, powers two
// - Source is system, fixed or external clock
// - External source still goes through prescaler
// - Free-running or bounded, up or up-down
// - Pin direction follows channel mode only
// - Capture on rise, fall or both; filter on channels 0 to 3
// - Compare match sets, clears or toggles output
// - Center-aligned PWM on every channel
// - Pair combines into one two-edge waveform
// - Pairs equal, complementary with deadtime, independent
// - Enabled fault forces pair outputs safe
// - Four fault inputs, each individually enabled
// - Output polarity per channel
// - Events for channel, overflow and fault
// - Buffered values load on chosen sync trigger
// - Write protection freezes critical configuration
// - Debug halt suspends counting, then resumes
// - Runs in wait; stopped clocks stop it
// - Quadrature mode counts from encoder phases
// - Dual-edge capture on a pair
// - Enhanced features off after reset
`timescale 1ns/1ns
`default_nettype none
module mctc_top (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  input  wire mctc_pkg::mctc_clksel_e          clock_source_select,
  input  wire logic [2:0]                      prescale_sel,
  input  wire logic                            debug_halt_state,
  input  wire logic                            free_run,
  input  wire logic                            up_down,
  input  wire logic                            signed_count,
  input  wire logic                            quad_mode,
  input  wire logic                            external_count_clock,
  input  wire logic                            fixed_freq_clock,
  input  wire logic                            encoder_phase_a,
  input  wire logic                            encoder_phase_b,
  input  wire logic [mctc_pkg::FLT_N-1:0]      fault_input,
  input  wire logic [mctc_pkg::FLT_N-1:0]      fault_input_enable,
  input  wire logic                            write_protect,
  input  wire mctc_pkg::mctc_pair_s [3:0]      pair_link_reg,
  input  wire mctc_pkg::mctc_chcfg_s [7:0]     chan_cfg,
  input  wire logic [mctc_pkg::CH_N-1:0]       polarity,
  input  wire logic [mctc_pkg::CNT_W-1:0]      mod_buf,
  input  wire logic [mctc_pkg::CNT_W-1:0]      cntin_buf,
  input  wire logic [7:0][mctc_pkg::CNT_W-1:0] cval_buf,
  input  wire logic                            load_on_reload,
  input  wire logic                            sw_sync,
  input  wire logic [mctc_pkg::CH_N-1:0]       channel_pin_i,
  output logic [mctc_pkg::CH_N-1:0]            channel_pin_o,
  output logic [mctc_pkg::CH_N-1:0]            channel_pin_oe,
  output logic [mctc_pkg::CNT_W-1:0]           count_value,
  output logic [7:0][mctc_pkg::CNT_W-1:0]      capture_value,
  output logic [mctc_pkg::CH_N-1:0]            channel_event,
  output logic                                 overflow_event,
  output logic                                 fault_event,
  output logic                                 fault_active
);
  import mctc_pkg::*;

  // Less-than in the chosen number format
  function automatic logic cnt_lt(input logic [CNT_W-1:0] a, b, input logic sgn);
    cnt_lt = sgn ? ($signed(a) < $signed(b)) : (a < b);
  endfunction

  logic [SYNC_W-1:0]       sy1_q;      // First synchroniser stage
  logic [SYNC_W-1:0]       sy2_q;      // Second stage, safe to read
  logic [SYNC_W-1:0]       sy3_q;      // Previous value for edge detection
  mctc_clksel_e            clksel_q;   // Protected copies of critical setup
  logic [2:0]              ps_sel_q;
  mctc_pair_s [3:0]        pair_q;
  logic [CH_N-1:0]         pol_q;
  logic [FLT_N-1:0]        flt_en_q;
  logic [PS_W-1:0]         ps_cnt_q;   // Prescaler divider
  logic [CNT_W-1:0]        cnt_q;      // Counter
  logic                    down_q;     // Counting down in up-down mode
  logic [CNT_W-1:0]        mod_q;      // Active final value
  logic [CNT_W-1:0]        cntin_q;    // Active initial value
  logic [7:0][CNT_W-1:0]   cval_q;     // Active channel values
  logic [CH_N-1:0]         filt_q;     // Filtered channel inputs
  logic [7:0][2:0]         fcnt_q;     // Filter hold counters
  logic [CH_N-1:0]         filt_prev_q;
  logic [CH_N-1:0]         cmp_q;      // Compare-mode output state
  logic [CH_N-1:0]         pre_q;      // Pair output before deadtime
  logic [3:0][5:0]         dt_q;       // Deadtime counters
  logic                    flt_q;      // Fault registered, follows fault_now each cycle

  logic                    src_edge;   // Selected source has ticked
  logic                    tick;       // Counter advances this cycle
  logic                    qd_step;
  logic                    qd_up;
  logic [CNT_W-1:0]        lo;
  logic [CNT_W-1:0]        hi;
  logic                    reload;     // Counter wraps or turns at the top
  logic                    fault_now;
  logic [CH_N-1:0]         raw;        // Per-channel waveform
  logic [CH_N-1:0]         pre;        // After pair combining
  logic [CH_N-1:0]         cap_hit;

  // Two-flop pin synchronisers plus an edge history stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
    end else begin
      sy1_q <= {channel_pin_i, fault_input, encoder_phase_b, encoder_phase_a,
                fixed_freq_clock, external_count_clock};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  // Critical setup follows its ports only while unprotected
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clksel_q <= CS_NONE;
      ps_sel_q <= '0;
      pair_q   <= '0;
      pol_q    <= '0;
      flt_en_q <= '0;
    end else if (!write_protect) begin
      clksel_q <= clock_source_select;
      ps_sel_q <= prescale_sel;
      pair_q   <= pair_link_reg;
      pol_q    <= polarity;
      flt_en_q <= fault_input_enable;
    end
  end

  // Source tick; a sampled pin must stay well below ref_clk
  always_comb begin
    case (clksel_q)
      CS_SYS:   src_edge = 1'b1;
      CS_FIXED: src_edge = sy2_q[SY_FIX] & ~sy3_q[SY_FIX];
      CS_EXT:   src_edge = sy2_q[SY_EXT] & ~sy3_q[SY_EXT];
      default:  src_edge = 1'b0;
    endcase
    qd_step = (sy2_q[SY_PHA] ^ sy3_q[SY_PHA]) | (sy2_q[SY_PHB] ^ sy3_q[SY_PHB]);
    qd_up = sy2_q[SY_PHA] ^ sy3_q[SY_PHB];
    if (quad_mode) begin
      tick = qd_step & ~debug_halt_state;
    end else begin
      tick = src_edge & ~debug_halt_state & (ps_cnt_q >= PS_W'((1 << ps_sel_q) - 1));
    end
  end

  // Prescaler; frozen in halt so the phase resumes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ps_cnt_q <= '0;
    end else if (src_edge && !debug_halt_state) begin
      ps_cnt_q <= tick ? '0 : ps_cnt_q + PS_W'(1);
    end
  end

  // Limits and the wrap point, also a load trigger
  always_comb begin
    lo = free_run ? FREE_MIN : cntin_q;
    hi = free_run ? FREE_MAX : mod_q;
    reload = tick && !quad_mode && (up_down ? (!down_q && cnt_q == hi) : (cnt_q == hi));
  end

  // Counter: up, up-down, or encoder-driven
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= CNT_RST;
      down_q <= 1'b0;
    end else if (tick) begin
      if (quad_mode) begin
        cnt_q <= qd_up ? cnt_q + CNT_W'(1) : cnt_q - CNT_W'(1);
      end else if (!up_down) begin
        cnt_q <= (cnt_q == hi) ? lo : cnt_q + CNT_W'(1);
      end else if (!down_q) begin
        down_q <= (cnt_q == hi);
        cnt_q  <= (cnt_q == hi) ? cnt_q - CNT_W'(1) : cnt_q + CNT_W'(1);
      end else begin
        down_q <= !(cnt_q == lo);
        cnt_q  <= (cnt_q == lo) ? cnt_q + CNT_W'(1) : cnt_q - CNT_W'(1);
      end
    end
  end

  // Buffers load on the chosen trigger only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_q   <= CNT_RST;
      cntin_q <= CNT_RST;
      cval_q  <= '0;
    end else if (sw_sync || (load_on_reload && reload)) begin
      mod_q   <= mod_buf;
      cntin_q <= cntin_buf;
      cval_q  <= cval_buf;
    end
  end

  // Low-channel filter: a level passes once it has held
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q      <= '0;
      fcnt_q      <= '0;
      filt_prev_q <= '0;
    end else begin
      filt_prev_q <= filt_q;
      for (int n = 0; n < CH_N; n++) begin
        if (n >= FILT_CH || !chan_cfg[n].filt_en) begin
          filt_q[n] <= sy2_q[SY_CH+n];
          fcnt_q[n] <= '0;
        end else if (sy2_q[SY_CH+n] == filt_q[n]) begin
          fcnt_q[n] <= '0;
        end else if (fcnt_q[n] == FILT_LEN - 3'h1) begin
          filt_q[n] <= sy2_q[SY_CH+n];
          fcnt_q[n] <= '0;
        end else begin
          fcnt_q[n] <= fcnt_q[n] + 3'h1;
        end
      end
    end
  end

  // Capture edges; a dual pair watches the even input
  always_comb begin
    for (int n = 0; n < CH_N; n++) begin
      logic rise;
      logic fall;
      int   src;
      src = (pair_q[n/2].dual_cap) ? (n & ~1) : n;
      rise = filt_q[src] & ~filt_prev_q[src];
      fall = ~filt_q[src] & filt_prev_q[src];
      if (pair_q[n/2].dual_cap) begin
        cap_hit[n] = (n % 2 == 0) ? rise : fall;
      end else begin
        case (chan_cfg[n].act)
          ACT_RISE: cap_hit[n] = rise;
          ACT_FALL: cap_hit[n] = fall;
          default:  cap_hit[n] = rise | fall;
        endcase
      end
      cap_hit[n] = cap_hit[n] && (chan_cfg[n].mode == CM_CAPTURE);
    end
  end

  // Compare outputs act on a match at the counter's advance
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_q <= '0;
    end else begin
      for (int n = 0; n < CH_N; n++) begin
        if (tick && chan_cfg[n].mode == CM_COMPARE && cnt_q == cval_q[n]) begin
          case (chan_cfg[n].act)
            ACT_RISE: cmp_q[n] <= 1'b1;
            ACT_FALL: cmp_q[n] <= 1'b0;
            default:  cmp_q[n] <= ~cmp_q[n];
          endcase
        end
      end
    end
  end

  // Waveforms and pair combining; up-down gives centre alignment
  always_comb begin
    for (int n = 0; n < CH_N; n++) begin
      raw[n] = (chan_cfg[n].mode == CM_PWM) ? cnt_lt(cnt_q, cval_q[n], signed_count) : cmp_q[n];
    end
    for (int p = 0; p < PAIR_N; p++) begin
      logic a;
      a = pair_q[p].combine ?
          (!cnt_lt(cnt_q, cval_q[2*p], signed_count) && cnt_lt(cnt_q, cval_q[2*p+1], signed_count)) :
          raw[2*p];
      pre[2*p]   = a;
      pre[2*p+1] = pair_q[p].comp ? ~a : (pair_q[p].combine ? a : raw[2*p+1]);
    end
  end

  // Deadtime: a complementary switch rests both sides
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
      dt_q  <= '0;
    end else begin
      pre_q <= pre;
      for (int p = 0; p < PAIR_N; p++) begin
        if (pair_q[p].comp && pre[2*p] != pre_q[2*p]) begin
          dt_q[p] <= pair_q[p].deadtime;
        end else if (dt_q[p] != DT_RST) begin
          dt_q[p] <= dt_q[p] - 6'h01;
        end
      end
    end
  end

  // Only enabled fault inputs count; held while asserted
  assign fault_now = |(sy2_q[SY_FLT +: FLT_N] & flt_en_q);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flt_q <= 1'b0;
    end else begin
      flt_q <= fault_now;
    end
  end

  // Pin stage: deadtime, polarity, fault override, direction from mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_pin_o  <= '0;
      channel_pin_oe <= '0;
    end else begin
      for (int n = 0; n < CH_N; n++) begin
        logic lvl;
        lvl = (pair_q[n/2].comp && dt_q[n/2] != DT_RST) ? 1'b0 : pre_q[n];
        lvl = lvl ^ pol_q[n];
        if (flt_q && pair_q[n/2].pair_fault_enable && pair_q[n/2].pair_fault_mode != 2'b00) begin
          lvl = pol_q[n];
        end
        channel_pin_o[n]  <= lvl;
        channel_pin_oe[n] <= chan_cfg[n].mode inside {CM_COMPARE, CM_PWM};
      end
    end
  end

  // Captured values, counter view and event pulses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_value  <= '0;
      count_value    <= CNT_RST;
      channel_event  <= '0;
      overflow_event <= 1'b0;
      fault_event    <= 1'b0;
      fault_active   <= 1'b0;
    end else begin
      count_value    <= cnt_q;
      overflow_event <= reload;
      fault_event    <= fault_now & ~flt_q;
      fault_active   <= flt_q;
      for (int n = 0; n < CH_N; n++) begin
        if (cap_hit[n]) begin
          capture_value[n] <= cnt_q;
        end
        channel_event[n] <= cap_hit[n] ||
                            (tick && chan_cfg[n].mode != CM_CAPTURE && cnt_q == cval_q[n]);
      end
    end
  end
  // Wait needs nothing; stopped clocks stop the block

endmodule
`default_nettype wire

/* tb/mctc_checker.sv */
/*
  Port-level timing checks of the timer core.
  Assumes it is bound into mctc_top and sampled on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module mctc_checker
  import mctc_pkg::*;
(
  input wire logic                        ref_clk,
  input wire logic                        rst_n,
  input wire mctc_pkg::mctc_clksel_e      clock_source_select,
  input wire logic [2:0]                  prescale_sel,
  input wire logic                        debug_halt_state,
  input wire logic                        free_run,
  input wire logic                        up_down,
  input wire logic                        quad_mode,
  input wire logic [3:0]                  fault_input,
  input wire logic [3:0]                  fault_input_enable,
  input wire logic                        write_protect,
  input wire mctc_pkg::mctc_pair_s [3:0]  pair_link_reg,
  input wire mctc_pkg::mctc_chcfg_s [7:0] chan_cfg,
  input wire logic [7:0]                  polarity,
  input wire logic [7:0]                  channel_pin_o,
  input wire logic [7:0]                  channel_pin_oe,
  input wire logic [15:0]                 count_value,
  input wire logic [7:0]                  channel_event,
  input wire logic                        overflow_event,
  input wire logic                        fault_event,
  input wire logic                        fault_active
);
  logic run;  // System clock counting with nothing frozen
  logic flt;  // Pair 1 fault forcing is armed
  assign run = clock_source_select == CS_SYS && !debug_halt_state && !quad_mode && !write_protect;
  assign flt = pair_link_reg[1].pair_fault_enable && pair_link_reg[1].pair_fault_mode != 2'h0;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  reset_quiet_a: assert property ($rose(rst_n) |-> channel_pin_oe == 8'h00 && !fault_active)
    else $error("output active after reset");
  halt_freeze_a: assert property (debug_halt_state [*3] |-> $stable(count_value))
    else $error("counter moved in halt");
  // Config is registered, so settings hold a few cycles
  no_source_a: assert property ((clock_source_select == CS_NONE && !quad_mode && !write_protect) [*4]
    |-> $stable(count_value))
    else $error("counter moved without source");
  sys_count_a: assert property ((run && prescale_sel == 3'h0 && free_run && !up_down) [*4]
    ##0 count_value != 16'hFFFF |=> count_value == $past(count_value) + 16'h0001)
    else $error("counter did not step by one");
  prescale_hold_a: assert property ((run && prescale_sel == 3'h1) [*4] ##0 $changed(count_value)
    |=> $stable(count_value))
    else $error("ratio two stepped twice");
  fault_set_a: assert property ((fault_input[0] && fault_input_enable[0] && !write_protect) [*6]
    |-> fault_active)
    else $error("enabled fault not seen");
  fault_clear_a: assert property ((!(|(fault_input & fault_input_enable)) && !write_protect) [*6]
    |-> !fault_active)
    else $error("fault held after release");
  fault_force_a: assert property ((fault_active && flt && chan_cfg[2].mode == CM_PWM && !write_protect) [*3]
    |-> channel_pin_o[2] == polarity[2])
    else $error("pin not at safe level");
  for (genvar i = 0; i < CH_N; i++) begin : g_dir
    out_dir_a: assert property ((chan_cfg[i].mode inside {CM_PWM, CM_COMPARE}) [*3] |-> channel_pin_oe[i])
      else $error("output mode not driving");
    in_dir_a: assert property ((chan_cfg[i].mode == CM_CAPTURE) [*3] |-> !channel_pin_oe[i])
      else $error("capture mode driving");
  end
  overflow_c: cover property (overflow_event);
  capture_c: cover property (channel_event[4]);
  fault_c: cover property (fault_event);
endmodule
bind mctc_top mctc_checker u_chk (.*);
`default_nettype wire

/* tb/mctc_partner.sv */
/*
  Far side of the timer: source clocks, encoder, fault lines, pin drivers.
  Assumes one bench process calls its tasks, just after ref_clk edges.
*/
`timescale 1ns/1ns
`default_nettype none
module mctc_partner (
  input  wire logic  ref_clk,
  output logic       external_count_clock,
  output logic       fixed_freq_clock,
  output logic       encoder_phase_a,
  output logic       encoder_phase_b,
  output logic [3:0] fault_input,
  output logic [7:0] pin_drive
);
  logic [1:0] pos;  // Encoder position, gray coded onto the phases
  initial begin
    {external_count_clock, fixed_freq_clock, encoder_phase_a, encoder_phase_b} = 4'h0;
    fault_input = 4'h0;
    pin_drive = 8'h00;
    pos = 2'h0;
  end
  // Toggles every four cycles: an eighth of ref_clk
  task automatic clk_burst(input logic fixed, input int n);
    repeat (2 * n) begin
      repeat (4) @(posedge ref_clk);
      #1;
      if (fixed) begin
        fixed_freq_clock = ~fixed_freq_clock;
      end else begin
        external_count_clock = ~external_count_clock;
      end
    end
  endtask
  // Gray steps, slow enough for the synchronisers
  task automatic quad_step(input int n, input logic fwd);
    repeat (n) begin
      repeat (4) @(posedge ref_clk);
      #1;
      pos = fwd ? pos + 2'h1 : pos - 2'h1;
      encoder_phase_a = pos[1];
      encoder_phase_b = pos[1] ^ pos[0];
    end
  endtask
endmodule
`default_nettype wire

/* tb/tb_motor_control_timer_core.sv */
/*
  Self-checking port-level bench of the timer core.
  Assumes the package, core, partner and checker compile first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_motor_control_timer_core;
  import mctc_pkg::*;
  logic ref_clk, rst_n, debug_halt_state, free_run, up_down, signed_count, quad_mode;
  logic write_protect, load_on_reload, sw_sync, overflow_event, fault_event, fault_active, v;
  mctc_clksel_e      clock_source_select;
  logic [2:0]        prescale_sel;
  logic [3:0]        fault_input_enable;
  mctc_pair_s [3:0]  pair_link_reg;
  mctc_chcfg_s [7:0] chan_cfg;
  logic [7:0]        polarity, channel_pin_o, channel_pin_oe, channel_event;
  logic [15:0]       mod_buf, cntin_buf, count_value, c0;
  logic [7:0][15:0]  cval_buf, capture_value;
  wire logic         external_count_clock, fixed_freq_clock, encoder_phase_a, encoder_phase_b;
  wire logic [3:0]   fault_input;
  wire logic [7:0]   pin_drive, channel_pin_i;
  int n_mismatch, check_count, n_cev4, n_cev5, n_fev, n_ovf, h, bl, bh;
  mctc_act_e acts[3] = '{ACT_RISE, ACT_FALL, ACT_BOTH};
  int cap_exp[3] = '{1, 1, 2};
  // Core wins where it drives
  assign channel_pin_i = (channel_pin_oe & channel_pin_o) | (~channel_pin_oe & pin_drive);
  mctc_top DUT (.*);
  mctc_partner P (.*);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // One-cycle pulses: count per edge
  always @(posedge ref_clk) begin
    n_cev4 <= n_cev4 + int'(channel_event[4] === 1'b1);
    n_cev5 <= n_cev5 + int'(channel_event[5] === 1'b1);
    n_fev <= n_fev + int'(fault_event === 1'b1);
    n_ovf <= n_ovf + int'(overflow_event === 1'b1);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t: %s", $time, msg);
    end
  endtask
  // One edge of sync strobe loads the buffers
  task automatic load();
    sw_sync = 1'b1;
    cyc(1);
    sw_sync = 1'b0;
    cyc(3);
  endtask
  // Over n cycles: h counts pin a high, bl both low, bh both high
  task automatic measure(input int a, input int b, input int n);
    h = 0;
    bl = 0;
    bh = 0;
    repeat (n) begin
      cyc(1);
      h += int'(channel_pin_o[a] === 1'b1);
      bl += int'(channel_pin_o[a] === 1'b0 && channel_pin_o[b] === 1'b0);
      bh += int'(channel_pin_o[a] === 1'b1 && channel_pin_o[b] === 1'b1);
    end
  endtask
  task automatic pulse4();
    P.pin_drive[4] = 1'b1;
    cyc(6);
    P.pin_drive[4] = 1'b0;
    cyc(6);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    {rst_n, debug_halt_state, free_run, up_down, signed_count, quad_mode} = 6'h00;
    {write_protect, load_on_reload, sw_sync} = 3'h0;
    clock_source_select = CS_SYS;
    prescale_sel = 3'h0;
    fault_input_enable = 4'h0;
    pair_link_reg = '0;
    chan_cfg = {8{5'h1A}};
    polarity = 8'h00;
    mod_buf = 16'h0009;
    cntin_buf = 16'h0000;
    cval_buf = '0;
    {n_mismatch, check_count, n_cev4, n_cev5, n_fev, n_ovf} = '0;
    cyc(16);
    rst_n = 1'b1;
    cyc(2);
    chk(channel_pin_oe === 8'h00 && fault_active === 1'b0, "reset outputs");
    // Compare on channel 1 against a ten-step count
    chan_cfg[1].mode = CM_COMPARE;
    cval_buf[1] = 16'h0005;
    load();
    for (int i = 0; i < 3; i++) begin
      chan_cfg[1].act = acts[i];
      cyc(24);
      v = channel_pin_o[1];
      cyc(10);
      chk(channel_pin_o[1] === ((i == 2) ? ~v : (i == 0)), "compare action");
    end
    chk(channel_pin_oe[1] === 1'b1, "compare drives");
    // Edge PWM; buffered value waits for sync
    chan_cfg[2].mode = CM_PWM;
    cval_buf[2] = 16'h0004;
    load();
    for (int p = 0; p < 2; p++) begin
      polarity[2] = p[0];
      cyc(4);
      measure(2, 3, 10);
      chk(h == (p ? 6 : 4), "pwm duty");
    end
    n_ovf = 0;
    cyc(20);
    chk(n_ovf == 2, "overflow count");
    cval_buf[2] = 16'h0007;
    measure(2, 3, 10);
    chk(h == 6, "buffer leaked");
    load();
    measure(2, 3, 10);
    chk(h == 3, "buffer not loaded");
    up_down = 1'b1;
    cyc(4);
    measure(2, 3, 36);
    chk(h > 0 && h < 36, "center pwm");
    up_down = 1'b0;
    // Combined pair 0: high from the even value up to the odd one
    pair_link_reg[0].combine = 1'b1;
    chan_cfg[0].mode = CM_PWM;
    cval_buf[0] = 16'h0002;
    cval_buf[1] = 16'h0006;
    cval_buf[2] = 16'h0004;
    polarity[2] = 1'b0;
    load();
    measure(0, 1, 10);
    chk(h == 4, "combined width");
    // Complementary pair 1, three-cycle gap
    chan_cfg[3].mode = CM_PWM;
    pair_link_reg[1].comp = 1'b1;
    pair_link_reg[1].deadtime = 6'h03;
    cyc(6);
    measure(2, 3, 20);
    chk(bh == 0 && bl >= 10, "deadtime gap");
    // Each fault line; only enabled ones force safe
    pair_link_reg[1].pair_fault_enable = 1'b1;
    pair_link_reg[1].pair_fault_mode = 2'h1;
    fault_input_enable = 4'h5;
    n_fev = 0;
    for (int j = 0; j < 4; j++) begin
      P.fault_input = 4'h1 << j;
      cyc(8);
      chk(fault_active === fault_input_enable[j], "fault detect");
      measure(2, 3, 4);
      chk(!fault_input_enable[j] || bl == 4, "safe level");
      P.fault_input = 4'h0;
      cyc(8);
      chk(fault_active === 1'b0, "fault release");
    end
    chk(n_fev == 2, "fault events");
    // Capture with the counter halted
    debug_halt_state = 1'b1;
    chan_cfg[4].mode = CM_CAPTURE;
    cyc(3);
    c0 = count_value;
    for (int i = 0; i < 3; i++) begin
      chan_cfg[4].act = acts[i];
      cyc(2);
      n_cev4 = 0;
      pulse4();
      chk(n_cev4 == cap_exp[i] && capture_value[4] === count_value, "capture");
    end
    pair_link_reg[2].dual_cap = 1'b1;
    chan_cfg[5].mode = CM_CAPTURE;
    cyc(2);
    n_cev4 = 0;
    n_cev5 = 0;
    pulse4();
    chk(n_cev4 == 1 && n_cev5 == 1, "dual capture");
    chk(count_value === c0, "halt held");
    debug_halt_state = 1'b0;
    cyc(4);
    chk(count_value !== c0, "no resume");
    // Fixed clock at ratio one, external clock at ratio two
    free_run = 1'b1;
    for (int s = 0; s < 2; s++) begin
      clock_source_select = s ? CS_EXT : CS_FIXED;
      prescale_sel = s[2:0];
      cyc(4);
      c0 = count_value;
      P.clk_burst(s == 0, 8);
      cyc(6);
      chk(16'(count_value - c0) === (s ? 16'h0004 : 16'h0008), "source count");
    end
    clock_source_select = CS_SYS;
    prescale_sel = 3'h0;
    cyc(3);
    write_protect = 1'b1;
    clock_source_select = CS_NONE;
    cyc(2);
    c0 = count_value;
    cyc(10);
    chk(16'(count_value - c0) === 16'h000A, "protect ignored");
    write_protect = 1'b0;
    clock_source_select = CS_SYS;
    cyc(8);
    prescale_sel = 3'h1;
    cyc(12);
    // Eight encoder steps out and back
    quad_mode = 1'b1;
    cyc(3);
    c0 = count_value;
    P.quad_step(8, 1'b1);
    cyc(6);
    chk(16'(count_value - c0) === 16'h0008 || 16'(c0 - count_value) === 16'h0008, "quad out");
    P.quad_step(8, 1'b0);
    cyc(6);
    chk(count_value === c0, "quad back");
    finish_test();
  end
endmodule
`default_nettype wire
